/* File: core/tofflg_top.v */
`timescale 1ns/10ps
`include "tofflg_map.vh"

// Thermal and overcurrent fault flag registers.
// The serial control engine outside this block turns host transactions
// into single-cycle register reads and writes on the port below.
module tofflg_top (
    input  wire       clk_sys,
    input  wire       reset,

    // Hot threshold comparators, high while a sensor is above threshold.
    input  wire       die_hot_sense,
    input  wire       termination_hot_sense,
    input  wire       top_right_hot_sense,
    input  wire       top_left_hot_sense,
    input  wire       bottom_right_hot_sense,

    // Critical threshold comparators, same five sensors.
    input  wire       die_crit_sense,
    input  wire       termination_crit_sense,
    input  wire       top_right_crit_sense,
    input  wire       top_left_crit_sense,
    input  wire       bottom_right_crit_sense,

    // Low-side FET overcurrent detectors of the step-down controllers.
    input  wire       controller_six_oc_sense,
    input  wire       controller_two_oc_sense,
    input  wire       controller_one_oc_sense,

    // Register access from the serial control engine.
    input  wire [7:0] reg_addr,
    input  wire       reg_wr_en,
    input  wire [7:0] reg_wr_data,
    input  wire       reg_rd_en,
    output wire [7:0] reg_rd_data,
    output wire       reg_rd_valid,
    output wire       reg_miss,

    // Live flag views for the rest of the power manager.
    output wire [7:0] temperature_critical_flags,
    output wire [7:0] temperature_hot_flags,
    output wire [7:0] overcurrent_flags,
    output wire       fault_active
);

    // Zero padding above the used fields of each register.
    localparam PAD_TEMP = `TOFFLG_REG_W - `TOFFLG_TEMP_W;
    localparam PAD_OC   = `TOFFLG_REG_W - `TOFFLG_OC_W;

    // Set requests gathered into field order.
    wire [`TOFFLG_TEMP_W-1:0] hot_set;
    wire [`TOFFLG_TEMP_W-1:0] crit_set;
    wire [`TOFFLG_OC_W-1:0]   oc_set;

    // Sticky flag fields.
    wire [`TOFFLG_TEMP_W-1:0] hot_field;
    wire [`TOFFLG_TEMP_W-1:0] crit_field;
    wire [`TOFFLG_OC_W-1:0]   oc_field;

    // Named views of the individual documented flags.
    wire                      termination_regulator_hot_flag;
    wire                      controller_six_overcurrent_flag;
    wire                      controller_two_overcurrent_flag;
    wire                      controller_one_overcurrent_flag;

    // Address decode.
    wire                      sel_crit;
    wire                      sel_hot;
    wire                      sel_oc;
    wire                      sel_any;

    // Write-one-to-clear strobes.
    wire                      wr_crit;
    wire                      wr_hot;
    wire                      wr_oc;

    // Full-width register images as the host sees them.
    wire [`TOFFLG_REG_W-1:0]  crit_image;
    wire [`TOFFLG_REG_W-1:0]  hot_image;
    wire [`TOFFLG_REG_W-1:0]  oc_image;

    // Read path.
    reg  [`TOFFLG_REG_W-1:0]  rd_mux;
    reg  [`TOFFLG_REG_W-1:0]  rd_data_ff;
    reg  [`TOFFLG_REG_W-1:0]  nxt_rd_data;
    reg                       rd_valid_ff;
    reg                       nxt_rd_valid;
    reg                       miss_ff;
    reg                       nxt_miss;

    // Each of the five sensors owns one hot flag bit.
    assign hot_set[`TOFFLG_BIT_DIE]       = die_hot_sense;
    assign hot_set[`TOFFLG_BIT_TERM]      = termination_hot_sense;
    assign hot_set[`TOFFLG_BIT_TOP_RIGHT] = top_right_hot_sense;
    assign hot_set[`TOFFLG_BIT_TOP_LEFT]  = top_left_hot_sense;
    assign hot_set[`TOFFLG_BIT_BOT_RIGHT] = bottom_right_hot_sense;

    // The critical flags use the same sensor to bit layout.
    assign crit_set[`TOFFLG_BIT_DIE]       = die_crit_sense;
    assign crit_set[`TOFFLG_BIT_TERM]      = termination_crit_sense;
    assign crit_set[`TOFFLG_BIT_TOP_RIGHT] = top_right_crit_sense;
    assign crit_set[`TOFFLG_BIT_TOP_LEFT]  = top_left_crit_sense;
    assign crit_set[`TOFFLG_BIT_BOT_RIGHT] = bottom_right_crit_sense;

    // Only three controllers have low-side current sensing.
    assign oc_set[`TOFFLG_BIT_CTL_SIX] = controller_six_oc_sense;
    assign oc_set[`TOFFLG_BIT_CTL_TWO] = controller_two_oc_sense;
    assign oc_set[`TOFFLG_BIT_CTL_ONE] = controller_one_oc_sense;

    // Decode is exact on all eight address bits; nothing aliases.
    assign sel_crit = (reg_addr == `TOFFLG_OFS_CRIT);
    assign sel_hot  = (reg_addr == `TOFFLG_OFS_HOT);
    assign sel_oc   = (reg_addr == `TOFFLG_OFS_OC);
    assign sel_any  = sel_crit | sel_hot | sel_oc;

    // A write reaches a bank only when its own address is selected.
    assign wr_crit = reg_wr_en & sel_crit;
    assign wr_hot  = reg_wr_en & sel_hot;
    assign wr_oc   = reg_wr_en & sel_oc;

    // Critical temperature flags.
    tofflg_w1c_bank #(
        .WIDTH    (`TOFFLG_TEMP_W)
    ) u_crit_bank (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .set_in   (crit_set),
        .clr_wr   (wr_crit),
        .clr_data (reg_wr_data[`TOFFLG_TEMP_W-1:0]),
        .flags    (crit_field)
    );

    // Hot temperature flags, one per sensor.
    tofflg_w1c_bank #(
        .WIDTH    (`TOFFLG_TEMP_W)
    ) u_hot_bank (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .set_in   (hot_set),
        .clr_wr   (wr_hot),
        .clr_data (reg_wr_data[`TOFFLG_TEMP_W-1:0]),
        .flags    (hot_field)
    );

    // Low-side overcurrent flags.
    tofflg_w1c_bank #(
        .WIDTH    (`TOFFLG_OC_W)
    ) u_oc_bank (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .set_in   (oc_set),
        .clr_wr   (wr_oc),
        .clr_data (reg_wr_data[`TOFFLG_OC_W-1:0]),
        .flags    (oc_field)
    );

    // Reserved upper bits have no storage at all, so writes cannot land.
    assign crit_image = {{PAD_TEMP{1'h0}}, crit_field};
    assign hot_image  = {{PAD_TEMP{1'h0}}, hot_field};
    assign oc_image   = {{PAD_OC{1'h0}},   oc_field};

    // Named single-flag views, kept for the neighbouring fault logic.
    assign termination_regulator_hot_flag  = hot_field[`TOFFLG_BIT_TERM];
    assign controller_six_overcurrent_flag = oc_field[`TOFFLG_BIT_CTL_SIX];
    assign controller_two_overcurrent_flag = oc_field[`TOFFLG_BIT_CTL_TWO];
    assign controller_one_overcurrent_flag = oc_field[`TOFFLG_BIT_CTL_ONE];

    // Read multiplexer; an unmapped address reads as zero.
    always @* begin
        rd_mux = `TOFFLG_RST_REG;
        case (1'h1)
            sel_crit: begin
                rd_mux = crit_image;
            end
            sel_hot: begin
                rd_mux = hot_image;
            end
            sel_oc: begin
                rd_mux = oc_image;
            end
            default: begin
                rd_mux = `TOFFLG_RST_REG;
            end
        endcase
    end

    // Read data is captured from the flags before any same-cycle clear,
    // so a read-and-clear sequence never loses an event it reported.
    always @* begin
        nxt_rd_data  = rd_data_ff;
        nxt_rd_valid = 1'h0;
        if (reg_rd_en) begin
            nxt_rd_data  = rd_mux;
            nxt_rd_valid = 1'h1;
        end
    end

    // An access to an address outside this bank is flagged for one cycle,
    // letting the serial engine decide whether to refuse it.
    always @* begin
        nxt_miss = (reg_rd_en | reg_wr_en) & ~sel_any;
    end

    // Read and miss registers.
    always @(posedge clk_sys) begin
        if (reset) begin
            rd_data_ff  <= `TOFFLG_RST_REG;
            rd_valid_ff <= 1'h0;
            miss_ff     <= 1'h0;
        end else begin
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
            miss_ff     <= nxt_miss;
        end
    end

    // Outputs.
    assign reg_rd_data  = rd_data_ff;
    assign reg_rd_valid = rd_valid_ff;
    assign reg_miss     = miss_ff;

    // Live flag views; these come straight from the flag flip-flops.
    assign temperature_critical_flags = crit_image;
    assign temperature_hot_flags      = hot_image;
    assign overcurrent_flags          = oc_image;

    // Summary of every flag, one flop deep from the sensors.
    assign fault_active = termination_regulator_hot_flag  |
                          controller_six_overcurrent_flag |
                          controller_two_overcurrent_flag |
                          controller_one_overcurrent_flag |
                          (|crit_field) | (|hot_field);

endmodule

/* File: core/tofflg_map.vh */
// Overview of operation
// - Five die temperature sensors each drive their own hot flag in the hot register.
// - Hot register bit 4 sets when the general die sensor exceeds the hot threshold.
// - Hot register bit 3 sets when the termination regulator sensor runs hot.
// - Hot register bit 2 sets when the top-right corner sensor runs hot.
// - Hot register bit 1 sets when the top-left corner sensor runs hot.
// - Hot register bit 0 sets when the bottom-right corner sensor runs hot.
// - Overcurrent bit 2 sets on low-side overcurrent of controller six.
// - Overcurrent bit 1 sets on low-side overcurrent of controller two.
// - Overcurrent bit 0 sets on low-side overcurrent of controller one.
// - Flags stay set until the host writes one; writing zero changes nothing.
// - The hot flag register sits at offset B5h.
// - Overcurrent register sits at B6h; both registers read zero after reset.
// - A critical flag register at B4h holds the same five sensor flags.
`ifndef TOFFLG_MAP_VH
`define TOFFLG_MAP_VH

// Register offsets within the device map.
`define TOFFLG_OFS_CRIT        8'hB4
`define TOFFLG_OFS_HOT         8'hB5
`define TOFFLG_OFS_OC          8'hB6

// Register and field widths.
`define TOFFLG_REG_W           8
`define TOFFLG_TEMP_W          5
`define TOFFLG_OC_W            3

// Bit positions of the temperature sensor flags.
`define TOFFLG_BIT_DIE         4
`define TOFFLG_BIT_TERM        3
`define TOFFLG_BIT_TOP_RIGHT   2
`define TOFFLG_BIT_TOP_LEFT    1
`define TOFFLG_BIT_BOT_RIGHT   0

// Bit positions of the overcurrent flags.
`define TOFFLG_BIT_CTL_SIX     2
`define TOFFLG_BIT_CTL_TWO     1
`define TOFFLG_BIT_CTL_ONE     0

// Reset values.
`define TOFFLG_RST_REG         8'h00
`define TOFFLG_RST_TEMP        5'h00
`define TOFFLG_RST_OC          3'h0
`define TOFFLG_RST_BIT         1'h0

`endif

/* File: core/tofflg_w1c_bank.v */
`timescale 1ns/10ps
`include "tofflg_map.vh"

// A row of sticky fault flags that the host clears by writing ones.
module tofflg_w1c_bank #(
    parameter WIDTH = 5
) (
    input  wire             clk_sys,
    input  wire             reset,
    input  wire [WIDTH-1:0] set_in,
    input  wire             clr_wr,
    input  wire [WIDTH-1:0] clr_data,
    output wire [WIDTH-1:0] flags
);

    reg  [WIDTH-1:0] flag_ff;
    wire [WIDTH-1:0] nxt_flag;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // Set beats clear, so an event in the clearing cycle survives.
            assign nxt_flag[i] = set_in[i] |
                                 (flag_ff[i] & ~(clr_wr & clr_data[i]));
        end
    endgenerate

    // One process owns the whole row, so every bit has a single driver.
    always @(posedge clk_sys) begin
        if (reset) begin
            flag_ff <= {WIDTH{`TOFFLG_RST_BIT}};
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flags = flag_ff;

endmodule

/* File: sim/tofflg_monitor.sv */
`timescale 1ns/10ps
// Watches the flag bank from its top-level ports.
module tofflg_monitor (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       die_hot_sense,
    input wire logic       controller_six_oc_sense,
    input wire logic       controller_one_oc_sense,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    input wire logic       reg_rd_valid,
    input wire logic       reg_miss,
    input wire logic [7:0] temperature_hot_flags,
    input wire logic [7:0] overcurrent_flags,
    input wire logic       fault_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // A write of one to the lowest overcurrent flag while its sensor rests.
    sequence s_oc_clear;
        reg_wr_en && reg_addr == 8'hB6 && reg_wr_data[0]
            && !controller_one_oc_sense;
    endsequence
    sequence s_hot_read;
        reg_rd_en && reg_addr == 8'hB5;
    endsequence
    rd_valid_a: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read strobe gave no valid pulse");
    hot_read_a: assert property (s_hot_read |=>
        reg_rd_data == $past(temperature_hot_flags))
        else $error("hot register read returned wrong image");
    oc_read_a: assert property (reg_rd_en && reg_addr == 8'hB6 |=>
        reg_rd_data == $past(overcurrent_flags))
        else $error("overcurrent register read returned wrong image");
    miss_flag_a: assert property ((reg_rd_en || reg_wr_en) &&
        (reg_addr < 8'hB4 || reg_addr > 8'hB6) |=> reg_miss)
        else $error("unmapped access gave no miss pulse");
    die_set_a: assert property (die_hot_sense |=>
        temperature_hot_flags[4] && fault_active)
        else $error("die hot flag did not set");
    six_set_a: assert property (controller_six_oc_sense |=>
        overcurrent_flags[2])
        else $error("controller six overcurrent flag did not set");
    upper_zero_a: assert property (temperature_hot_flags[7:5] == 3'h0
        && overcurrent_flags[7:3] == 5'h00)
        else $error("unused flag bits not zero");
    oc_clear_a: assert property (s_oc_clear |=> !overcurrent_flags[0])
        else $error("write of one left flag set");
    sticky_a: assert property ($fell(temperature_hot_flags[4]) |->
        $past(reg_wr_en && reg_addr == 8'hB5 && reg_wr_data[4]))
        else $error("hot flag cleared without a write of one");
endmodule

bind tofflg_top tofflg_monitor u_mon (.*);

/* File: sim/tofflg_host.sv */
`timescale 1ns/10ps
// Host side of the register port, driving at the falling edge.
module tofflg_host (
    input  wire logic       clk_sys,
    output logic      [7:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wr_data,
    output logic            reg_rd_en,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_valid,
    input  wire logic       reg_miss
);
    // Idle values; strobes low so nothing is taken during reset.
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end
    // One-cycle write; ones clear flags and zeros leave them alone.
    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wr_data = wd;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        // Released lines flip, so a stale value can never pass as good.
        reg_addr = ~a;
        reg_wr_data = ~wd;
    endtask
    // One-cycle read; the answer is picked up one cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] rdat,
                      output logic v, output logic m);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        rdat = reg_rd_data;
        v = reg_rd_valid;
        m = reg_miss;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

/* File: sim/test_thermal_overcurrent_fault_flags.sv */
`timescale 1ns/10ps
module test_thermal_overcurrent_fault_flags;
    logic        clk_sys;
    logic        reset;
    logic [12:0] sense;
    logic [7:0]  reg_addr;
    logic        reg_wr_en;
    logic [7:0]  reg_wr_data;
    logic        reg_rd_en;
    wire  [7:0]  reg_rd_data;
    wire         reg_rd_valid;
    wire         reg_miss;
    wire  [7:0]  temperature_critical_flags;
    wire  [7:0]  temperature_hot_flags;
    wire  [7:0]  overcurrent_flags;
    wire         fault_active;
    logic [7:0]  d;
    logic [7:0]  exp_v;
    logic        v;
    logic        m;
    int          miscompares;
    int          comparisons;
    int          base[3] = '{5, 0, 10};
    int          nb[3] = '{5, 5, 3};

    // Sense vector is {overcurrent, critical, hot}, bit order as flags.
    tofflg_top u_tofflg_top (.clk_sys(clk_sys), .reset(reset),
        .die_hot_sense(sense[4]), .termination_hot_sense(sense[3]),
        .top_right_hot_sense(sense[2]), .top_left_hot_sense(sense[1]),
        .bottom_right_hot_sense(sense[0]), .die_crit_sense(sense[9]),
        .termination_crit_sense(sense[8]), .top_right_crit_sense(sense[7]),
        .top_left_crit_sense(sense[6]), .bottom_right_crit_sense(sense[5]),
        .controller_six_oc_sense(sense[12]),
        .controller_two_oc_sense(sense[11]),
        .controller_one_oc_sense(sense[10]), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .reg_miss(reg_miss),
        .temperature_critical_flags(temperature_critical_flags),
        .temperature_hot_flags(temperature_hot_flags),
        .overcurrent_flags(overcurrent_flags), .fault_active(fault_active));
    tofflg_host u_tofflg_host (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .reg_miss(reg_miss));

    // Free-running 200 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic check(input string n, input logic [7:0] s, e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Read, then compare data and the valid and miss pulses.
    task automatic rchk(input logic [7:0] a, e);
        u_tofflg_host.rd(a, d, v, m);
        check("read data", d, e);
        check("valid miss", {v, m}, {1'b1, a < 8'hB4 || a > 8'hB6});
    endtask
    // A hang costs a mismatch rather than a silent stall.
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
    initial begin
        reset = 1'b1;
        sense = 13'h0000;
        repeat (3) @(negedge clk_sys);
        reset = 1'b0;
        for (int r = 0; r < 3; r++) rchk(8'(8'hB4 + r), 8'h00);
        rchk(8'hB7, 8'h00);
        rchk(8'hB3, 8'h00);
        // Each sensor gets a single-cycle pulse; flags must accumulate.
        for (int r = 0; r < 3; r++) begin
            exp_v = 8'h00;
            for (int i = 0; i < nb[r]; i++) begin
                @(negedge clk_sys);
                sense[base[r] + i] = 1'b1;
                @(negedge clk_sys);
                sense[base[r] + i] = 1'b0;
                exp_v[i] = 1'b1;
                rchk(8'(8'hB4 + r), exp_v);
                d = (r == 2) ? overcurrent_flags : temperature_hot_flags;
                if (r == 0) d = temperature_critical_flags;
                check("live flags", d, exp_v);
            end
            u_tofflg_host.wr(8'(8'hB4 + r), 8'h00);
            rchk(8'(8'hB4 + r), exp_v);
            u_tofflg_host.wr(8'(8'hB4 + r), 8'hEA);
            rchk(8'(8'hB4 + r), exp_v & 8'h15);
            u_tofflg_host.wr(8'(8'hB4 + r), 8'hFF);
            rchk(8'(8'hB4 + r), 8'h00);
        end
        // A sensor still tripped keeps its flag through a clear.
        @(negedge clk_sys);
        sense[10] = 1'b1;
        u_tofflg_host.wr(8'hB6, 8'h01);
        check("oc flags", overcurrent_flags, 8'h01);
        check("fault", {7'h00, fault_active}, 8'h01);
        sense[10] = 1'b0;
        u_tofflg_host.wr(8'hB6, 8'h01);
        check("oc flags", overcurrent_flags, 8'h00);
        check("fault", {7'h00, fault_active}, 8'h00);
        // Every flag set, then writes off the map must leave them alone.
        @(negedge clk_sys);
        sense = 13'h1FFF;
        @(negedge clk_sys);
        sense = 13'h0000;
        u_tofflg_host.wr(8'hB3, 8'hFF);
        u_tofflg_host.wr(8'hB7, 8'hFF);
        check("miss", {7'h00, reg_miss}, 8'h01);
        check("crit flags", temperature_critical_flags, 8'h1F);
        check("hot flags", temperature_hot_flags, 8'h1F);
        check("oc flags", overcurrent_flags, 8'h07);
        // A reset in mid-run wipes flags that were never cleared.
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        check("hot flags", temperature_hot_flags, 8'h00);
        check("fault", {7'h00, fault_active}, 8'h00);
        for (int r = 0; r < 3; r++) rchk(8'(8'hB4 + r), 8'h00);
        stop_test();
    end
endmodule
